// file: pkg/lv_reset_defines.svh
`ifndef LV_RESET_DEFINES_SVH
`define LV_RESET_DEFINES_SVH

// Register byte offsets on the APB bus.
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_THREE 8'h04
`define OFS_RESET_SOURCE 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10

// power_ctrl_one fields.
`define BIT_DETECT_ENABLE 0
`define BIT_DETECT_STOP_ENABLE 1
`define BIT_DETECT_RESET_SELECT 2
`define BIT_DETECT_IRQ_ENABLE 3
`define BIT_DETECT_FLAG 4
`define CTRL_ONE_WIDTH 4
`define CTRL_ONE_RESET 4'h5

// power_ctrl_three fields.
`define BIT_DETECT_TRIP_SELECT 0
`define BIT_WARNING_TRIP_SELECT 1
`define BIT_SUPPLY_WARNING 2
`define CTRL_THREE_WIDTH 2
`define CTRL_THREE_RESET 2'h0

// reset_source_status fields.
`define BIT_RSS_POWER_ON 7
`define BIT_RSS_PIN 6
`define BIT_RSS_WATCHDOG 5
`define BIT_RSS_ILLEGAL_OPCODE 4
`define BIT_RSS_ILLEGAL_ADDRESS 3
`define BIT_RSS_LOW_VOLTAGE 1
`define RSS_POWER_ON_VALUE 8'h82
`define RSS_CLEAR 8'h00

// Interrupt status and mask fields.
`define STAT_DETECT 0
`define STAT_WARNING 1
`define STAT_WIDTH 2
`define MASK_RESET 2'h0

// Vector addresses, high byte first.
`define RESET_VECTOR_ADDR 16'hFFFE
`define DETECT_VECTOR_ADDR 16'hFFF8
`define VECTOR_LOW_STEP 16'h0001

// Stop levels.
`define STOP_LEVEL_THREE 2'h3

`endif

// file: pkg/lv_reset_pkg.sv
`default_nettype none
package lv_reset_pkg;

    typedef struct packed {
        logic por_detect;
        logic below_high;
        logic below_low;
        logic warn_high;
        logic warn_low;
    } comparator_t;

    typedef struct packed {
        logic watchdog;
        logic pin;
        logic illegal_opcode;
        logic illegal_address;
    } reset_src_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_LV_HOLD = 2'h2,
        ST_POR_HOLD = 2'h1,
        ST_SRC_HOLD = 2'h3
    } reset_state_t;

endpackage
`default_nettype wire

// file: design/comparator_sync.sv
`default_nettype none
module comparator_sync
    import lv_reset_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw and synchronised comparators
    input wire comparator_t raw,
    output comparator_t synced
);
    localparam int WIDTH = $bits(comparator_t);

    logic [WIDTH-1:0] raw_bits;
    logic [WIDTH-1:0] sync_bits;

    assign raw_bits = raw;
    assign synced = sync_bits;

    // Flops reset to ones so that a fresh power-up reads as low supply.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_q;
            logic stable_q;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_q <= 1'b1;
                    stable_q <= 1'b1;
                end
                else
                begin
                    meta_q <= raw_bits[i]; // R14
                    stable_q <= meta_q; // R14
                end
            end
            assign sync_bits[i] = stable_q;
        end
    endgenerate
endmodule
`default_nettype wire

// file: design/low_voltage_reset_irq_control.sv
// Overview of operation
// [R1] Detection acts only with detect enable set; trip select picks high or low.
// [R2] Stop modes turn detection off unless the stop enable bit is set.
// [R3] With detect and stop enable both set, stop1 and stop2 become stop3.
// [R4] Power-on detection resets and holds until supply exceeds low trip.
// [R5] Power-on reset sets both power-on and low-voltage reset flags.
// [R6] Reset select set plus low voltage resets, held until above selected trip.
// [R7] A low-voltage reset sets the low-voltage reset flag.
// [R8] Enabled interrupt mode sets detect flag and raises low-voltage request.
// [R9] Warning comparator sets warning flag that never raises an interrupt.
// [R10] Warning trip select picks the high or low warning threshold.
// [R11] Every reset source shares the single top reset vector.
// [R12] Flags always set; a request needs its local enable at one.
// [R13] Vector high byte sits at lower address, low byte next.
// [R14] Comparator outputs are synchronised before any use.
//
// Design decisions made here: the register offsets and the APB slave port.
`include "lv_reset_defines.svh"
`default_nettype none
module low_voltage_reset_irq_control
    import lv_reset_pkg::*;
(
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparators, asynchronous
    input wire comparator_t comparators,
    // Other reset sources; only watchdog and pin have enables
    input wire reset_src_t reset_sources,
    input wire logic watchdog_enable,
    input wire logic reset_pin_enable,
    // Stop mode handshake
    input wire logic stop_mode,
    input wire logic stop_req,
    input wire logic [1:0] stop_level,
    output logic stop_ack,
    output logic [1:0] stop_grant,
    output logic stop_refused,
    // System outputs
    output logic mcu_reset,
    output logic lv_irq,
    output logic [15:0] vector_hi_addr,
    output logic [15:0] vector_lo_addr,
    output logic watchdog_clear
);
    comparator_t cmp_s;
    logic [`CTRL_ONE_WIDTH-1:0] ctrl_one_q;
    logic [`CTRL_THREE_WIDTH-1:0] ctrl_three_q;
    logic [7:0] rss_q;
    logic [7:0] rss_d;
    logic [`STAT_WIDTH-1:0] stat_q;
    logic [`STAT_WIDTH-1:0] stat_d;
    logic [`STAT_WIDTH-1:0] mask_q;
    reset_state_t state_q;
    reset_state_t state_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic mcu_reset_q;
    logic [15:0] vec_hi_q;
    logic [15:0] vec_lo_q;
    logic [15:0] vec_sel;
    logic stop_ack_q;
    logic [1:0] stop_grant_q;
    logic stop_refused_q;
    logic wdog_clear_q;

    comparator_sync comparator_sync_i (
        .pclk(pclk),
        .presetn(presetn),
        .raw(comparators),
        .synced(cmp_s)
    );

    // Bus decode. One wait state lets every bus output come from a flop.
    logic hit_one;
    logic hit_three;
    logic hit_rss;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic capture;
    logic wr_done;
    logic [31:0] rd_word;
    assign hit_one = paddr == `OFS_CTRL_ONE;
    assign hit_three = paddr == `OFS_CTRL_THREE;
    assign hit_rss = paddr == `OFS_RESET_SOURCE;
    assign hit_stat = paddr == `OFS_IRQ_STATUS;
    assign hit_mask = paddr == `OFS_IRQ_MASK;
    assign mapped = hit_one | hit_three | hit_rss | hit_stat | hit_mask;
    assign capture = psel & penable & ~pready_q;
    assign wr_done = psel & penable & pready_q & pwrite & mapped;
    assign rd_word = hit_one ? 32'({stat_q[`STAT_DETECT], ctrl_one_q})
        : hit_three ? 32'({stat_q[`STAT_WARNING], ctrl_three_q})
        : hit_rss ? 32'(rss_q)
        : hit_stat ? 32'(stat_q)
        : hit_mask ? 32'(mask_q)
        : 32'h0000_0000;

    // Detection path.
    logic detect_active;
    logic below_sel;
    logic warn_sel;
    logic lv_event;
    logic lv_reset_req;
    logic det_set;
    logic warn_set;
    logic [3:0] src_active;
    logic any_src;
    logic supply_ok;
    // In stop the detector stays on only with its stop enable.
    assign detect_active = ctrl_one_q[`BIT_DETECT_ENABLE]
        & (~stop_mode | ctrl_one_q[`BIT_DETECT_STOP_ENABLE]); // R1 R2
    assign below_sel = ctrl_three_q[`BIT_DETECT_TRIP_SELECT]
        ? cmp_s.below_high : cmp_s.below_low; // R1
    assign warn_sel = ctrl_three_q[`BIT_WARNING_TRIP_SELECT]
        ? cmp_s.warn_high : cmp_s.warn_low; // R10
    assign lv_event = detect_active & below_sel;
    assign lv_reset_req = lv_event & ctrl_one_q[`BIT_DETECT_RESET_SELECT]; // R6
    assign det_set = lv_event & ~ctrl_one_q[`BIT_DETECT_RESET_SELECT]; // R8 R12
    assign warn_set = detect_active & warn_sel; // R9
    assign src_active = {reset_sources.watchdog & watchdog_enable,
        reset_sources.pin & reset_pin_enable,
        reset_sources.illegal_opcode, reset_sources.illegal_address};
    assign any_src = |src_active;
    assign supply_ok = ~cmp_s.por_detect & ~cmp_s.below_low; // R4

    // Reset sequencer.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
            begin
                if (cmp_s.por_detect)
                    state_d = ST_POR_HOLD; // R4
                else if (lv_reset_req)
                    state_d = ST_LV_HOLD; // R6
                else if (any_src)
                    state_d = ST_SRC_HOLD;
            end
            ST_POR_HOLD:
            begin
                if (supply_ok)
                    state_d = ST_RUN; // R4
            end
            ST_LV_HOLD:
            begin
                if (cmp_s.por_detect)
                    state_d = ST_POR_HOLD;
                else if (!below_sel)
                    state_d = ST_RUN; // R6
            end
            ST_SRC_HOLD:
            begin
                if (cmp_s.por_detect)
                    state_d = ST_POR_HOLD;
                else if (!any_src)
                    state_d = ST_RUN;
            end
            default:
                state_d = ST_POR_HOLD;
        endcase
    end

    // Reset source flags are rewritten only on entry to a reset.
    logic enter_por;
    logic enter_lv;
    logic enter_src;
    assign enter_por = state_q != ST_POR_HOLD && state_d == ST_POR_HOLD;
    assign enter_lv = state_q != ST_LV_HOLD && state_d == ST_LV_HOLD;
    assign enter_src = state_q != ST_SRC_HOLD && state_d == ST_SRC_HOLD;
    always_comb
    begin
        rss_d = rss_q;
        if (enter_por)
            rss_d = `RSS_POWER_ON_VALUE; // R5
        else if (enter_lv)
        begin
            rss_d = `RSS_CLEAR;
            rss_d[`BIT_RSS_POWER_ON] = rss_q[`BIT_RSS_POWER_ON];
            rss_d[`BIT_RSS_LOW_VOLTAGE] = 1'b1; // R7
        end
        else if (enter_src)
        begin
            rss_d = `RSS_CLEAR;
            rss_d[`BIT_RSS_WATCHDOG] = src_active[3];
            rss_d[`BIT_RSS_PIN] = src_active[2];
            rss_d[`BIT_RSS_ILLEGAL_OPCODE] = src_active[1];
            rss_d[`BIT_RSS_ILLEGAL_ADDRESS] = src_active[0];
        end
    end

    // Sticky status, write one to clear; a set in the same cycle wins.
    logic [`STAT_WIDTH-1:0] stat_clr;
    logic [`STAT_WIDTH-1:0] stat_set;
    assign stat_clr = (wr_done & hit_stat) ? pwdata[`STAT_WIDTH-1:0] : `MASK_RESET;
    assign stat_set = {warn_set, det_set};
    assign stat_d = (stat_q & ~stat_clr) | stat_set; // R12

    // The warning bit is left out of the request on purpose.
    logic irq_d;
    assign irq_d = stat_q[`STAT_DETECT] & ctrl_one_q[`BIT_DETECT_IRQ_ENABLE]
        & mask_q[`STAT_DETECT]; // R8 R9 R12

    // Stop entry: a blocked deep stop is granted as stop3 instead.
    logic stop_block;
    assign stop_block = ctrl_one_q[`BIT_DETECT_ENABLE]
        & ctrl_one_q[`BIT_DETECT_STOP_ENABLE]
        & (stop_level != `STOP_LEVEL_THREE); // R3

    // Any reset, internal ones included, fetches the shared top vector.
    assign vec_sel = (state_d != ST_RUN) ? `RESET_VECTOR_ADDR : `DETECT_VECTOR_ADDR; // R11

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_POR_HOLD;
            rss_q <= `RSS_POWER_ON_VALUE;
            mcu_reset_q <= 1'b1;
            vec_hi_q <= `RESET_VECTOR_ADDR;
            vec_lo_q <= `RESET_VECTOR_ADDR + `VECTOR_LOW_STEP;
        end
        else
        begin
            state_q <= state_d;
            rss_q <= rss_d;
            mcu_reset_q <= state_d != ST_RUN; // R4 R6
            vec_hi_q <= vec_sel; // R11
            vec_lo_q <= vec_sel + `VECTOR_LOW_STEP; // R13
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_one_q <= `CTRL_ONE_RESET;
            ctrl_three_q <= `CTRL_THREE_RESET;
            mask_q <= `MASK_RESET;
            stat_q <= `MASK_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            if (wr_done && hit_one)
                ctrl_one_q <= pwdata[`CTRL_ONE_WIDTH-1:0];
            if (wr_done && hit_three)
                ctrl_three_q <= pwdata[`CTRL_THREE_WIDTH-1:0];
            if (wr_done && hit_mask)
                mask_q <= pwdata[`STAT_WIDTH-1:0];
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            wdog_clear_q <= 1'b0;
        end
        else
        begin
            pready_q <= capture;
            pslverr_q <= capture & ~mapped;
            if (capture)
                prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
            wdog_clear_q <= wr_done & hit_rss;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_ack_q <= 1'b0;
            stop_grant_q <= `STOP_LEVEL_THREE;
            stop_refused_q <= 1'b0;
        end
        else
        begin
            stop_ack_q <= stop_req;
            if (stop_req)
            begin
                stop_grant_q <= stop_block ? `STOP_LEVEL_THREE : stop_level; // R3
                stop_refused_q <= stop_block;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign lv_irq = irq_q;
    assign mcu_reset = mcu_reset_q;
    assign vector_hi_addr = vec_hi_q;
    assign vector_lo_addr = vec_lo_q; // R13
    assign stop_ack = stop_ack_q;
    assign stop_grant = stop_grant_q;
    assign stop_refused = stop_refused_q;
    assign watchdog_clear = wdog_clear_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    detect_gate_a: assert property ( // R1
        (!ctrl_one_q[`BIT_DETECT_ENABLE] && !stat_q[`STAT_DETECT]) |=> !stat_q[`STAT_DETECT])
        else $error("detect flag set while detection disabled");
    stop_gate_a: assert property ( // R2
        (stop_mode && !ctrl_one_q[`BIT_DETECT_STOP_ENABLE] && state_q == ST_RUN)
            |=> state_q != ST_LV_HOLD || $past(cmp_s.por_detect))
        else $error("low voltage reset taken in stop without stop enable");
    stop_block_a: assert property ( // R3
        (stop_req && stop_block) |=> stop_grant_q == `STOP_LEVEL_THREE && stop_refused_q)
        else $error("deep stop granted while detection kept in stop");
    por_hold_a: assert property ( // R4
        (state_q == ST_POR_HOLD && !supply_ok) |=> mcu_reset_q && state_q == ST_POR_HOLD)
        else $error("power-on reset released before supply recovered");
    por_flags_a: assert property ( // R5
        (state_q == ST_RUN && cmp_s.por_detect) |=> rss_q == `RSS_POWER_ON_VALUE && mcu_reset_q)
        else $error("power-on reset flags wrong");
    lv_reset_a: assert property ( // R6
        (state_q == ST_RUN && lv_reset_req && !cmp_s.por_detect)
            |=> mcu_reset_q && rss_q[`BIT_RSS_LOW_VOLTAGE])
        else $error("low voltage reset not taken"); // R7
    lv_release_a: assert property ( // R6
        (state_q == ST_LV_HOLD && !below_sel && !cmp_s.por_detect) |=> !mcu_reset_q)
        else $error("low voltage reset not released");
    irq_raise_a: assert property ( // R8
        (stat_q[`STAT_DETECT] && ctrl_one_q[`BIT_DETECT_IRQ_ENABLE] && mask_q[`STAT_DETECT])
            |=> lv_irq)
        else $error("low voltage interrupt missing");
    warn_quiet_a: assert property ( // R9
        !stat_q[`STAT_DETECT] |=> !lv_irq)
        else $error("interrupt without detect flag");
    reset_vector_a: assert property ( // R11
        mcu_reset_q |-> vector_hi_addr == `RESET_VECTOR_ADDR
            && vector_lo_addr == `RESET_VECTOR_ADDR + `VECTOR_LOW_STEP)
        else $error("reset vector address wrong");
endmodule
`default_nettype wire

// file: tb/supply_model.sv
`default_nettype none
module supply_model
    import lv_reset_pkg::*;
#(
    parameter int POR_LEVEL = 10,
    parameter int DETECT_LOW = 18,
    parameter int DETECT_HIGH = 21,
    parameter int WARN_LOW = 24,
    parameter int WARN_HIGH = 27
)
(
    // Supply level in arbitrary steps
    input wire logic [7:0] supply_level,
    // Comparator levels, high while the supply sits below each threshold
    output comparator_t comparators
);
    timeunit 1ns;
    timeprecision 1ns;

    // The analog side settles a little after the supply moves, so it never lines up with pclk.
    assign #3 comparators = {supply_level < POR_LEVEL, supply_level < DETECT_HIGH,
        supply_level < DETECT_LOW, supply_level < WARN_HIGH, supply_level < WARN_LOW};
endmodule
`default_nettype wire

// file: tb/test_low_voltage_reset_irq_control.sv
`include "lv_reset_defines.svh"
`default_nettype none
module test_low_voltage_reset_irq_control
    import lv_reset_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, stop_ack, stop_refused, mcu_reset, lv_irq, watchdog_clear, seen;
    logic [1:0] stop_grant;
    logic [1:0] stop_level = 2'h3;
    logic [15:0] vector_hi_addr, vector_lo_addr;
    logic stop_mode = 1'b0, stop_req = 1'b0, watchdog_enable = 1'b0, reset_pin_enable = 1'b0;
    reset_src_t reset_sources = '0;
    comparator_t comparators;
    logic [7:0] supply = 8'h00;
    logic [3:0] src;
    logic [32:0] expect_q[$];
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 81;
    int c1 [7] = '{8, 9, 9, 9, 11, 9, 9};
    int c3 [7] = '{0, 0, 1, 0, 0, 2, 0};
    int lv [7] = '{15, 20, 20, 15, 15, 25, 25};
    int sm [7] = '{0, 0, 0, 1, 1, 0, 0};
    int ex [7] = '{0, 2, 3, 0, 3, 2, 0};

    always #25 pclk = ~pclk;

    supply_model supply_model_i (.supply_level(supply), .comparators(comparators));

    low_voltage_reset_irq_control low_voltage_reset_irq_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparators(comparators), .reset_sources(reset_sources),
        .watchdog_enable(watchdog_enable), .reset_pin_enable(reset_pin_enable),
        .stop_mode(stop_mode), .stop_req(stop_req), .stop_level(stop_level),
        .stop_ack(stop_ack), .stop_grant(stop_grant), .stop_refused(stop_refused),
        .mcu_reset(mcu_reset), .lv_irq(lv_irq), .vector_hi_addr(vector_hi_addr),
        .vector_lo_addr(vector_lo_addr), .watchdog_clear(watchdog_clear)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        chk(nm, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic vec(input logic [15:0] hi);
        chk("vector high", {16'h0, hi}, {16'h0, vector_hi_addr});
        chk("vector low", {16'h0, hi + 16'h0001}, {16'h0, vector_lo_addr});
    endtask

    task automatic settle;
        repeat (8) @(posedge pclk);
        #1;
    endtask

    // For a read, d is the expected data; the bus carries noise on pwdata meanwhile.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        expect_q.push_back({a > 8'h10, (w || a > 8'h10) ? 32'h0000_0000 : d});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : $random(seed);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk1("pready", 1'b1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && expect_q.size() > 0)
        begin
            chk("prdata", expect_q[0][31:0], prdata);
            chk1("pslverr", expect_q[0][32], pslverr);
            void'(expect_q.pop_front());
        end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        tally_and_finish;
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk) supply <= 8'd15;
        settle;
        chk1("mcu_reset", 1'b1, mcu_reset);
        vec(16'hFFFE);
        @(posedge pclk) supply <= 8'd33;
        settle;
        chk1("mcu_reset", 1'b0, mcu_reset);
        vec(16'hFFF8);
        apb(1'b0, `OFS_RESET_SOURCE, 32'h0000_0082);
        apb(1'b0, `OFS_CTRL_ONE, 32'h0000_0005);
        apb(1'b0, 8'h14, 32'h0000_0000);
        $display("test power on done");
        apb(1'b1, `OFS_CTRL_ONE, 32'h0000_0009);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
        @(posedge pclk) supply <= 8'd15;
        settle;
        chk1("mcu_reset", 1'b0, mcu_reset);
        chk1("lv_irq", 1'b1, lv_irq);
        apb(1'b0, `OFS_CTRL_ONE, 32'h0000_0019);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0000);
        settle;
        chk1("lv_irq", 1'b0, lv_irq);
        @(posedge pclk) supply <= 8'd33;
        settle;
        apb(1'b1, `OFS_IRQ_STATUS, 32'h0000_0003);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
        apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0003);
        $display("test interrupt done");
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, `OFS_CTRL_ONE, c1[i]);
            apb(1'b1, `OFS_CTRL_THREE, c3[i]);
            @(posedge pclk);
            stop_mode <= sm[i][0];
            supply <= 8'(lv[i]);
            settle;
            apb(1'b0, `OFS_IRQ_STATUS, ex[i]);
            chk1("lv_irq", ex[i][0], lv_irq);
            @(posedge pclk);
            stop_mode <= 1'b0;
            supply <= 8'd33;
            settle;
            apb(1'b1, `OFS_IRQ_STATUS, 32'h0000_0003);
        end
        $display("test detection done");
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `OFS_CTRL_ONE, i < 3 ? 32'h0000_0003 : 32'h0000_0001);
            @(posedge pclk);
            stop_req <= 1'b1;
            stop_level <= 2'(i % 3 + 1);
            @(posedge pclk);
            stop_req <= 1'b0;
            #1;
            chk1("stop_ack", 1'b1, stop_ack);
            chk1("stop_refused", i < 2, stop_refused);
            chk("stop_grant", i < 2 ? 32'h3 : 32'(i % 3 + 1), {30'h0, stop_grant});
        end
        $display("test stop done");
        apb(1'b1, `OFS_CTRL_ONE, 32'h0000_0005);
        apb(1'b1, `OFS_CTRL_THREE, 32'h0000_0001);
        @(posedge pclk) supply <= 8'd20;
        settle;
        chk1("mcu_reset", 1'b1, mcu_reset);
        vec(16'hFFFE);
        settle;
        chk1("mcu_reset", 1'b1, mcu_reset);
        @(posedge pclk) supply <= 8'd22;
        settle;
        chk1("mcu_reset", 1'b0, mcu_reset);
        apb(1'b0, `OFS_RESET_SOURCE, 32'h0000_0082);
        $display("test low voltage reset done");
        watchdog_enable <= 1'b1;
        reset_pin_enable <= 1'b1;
        repeat (3)
        begin
            src = 4'($random(seed));
            if (src == 4'h0)
                src = 4'h4;
            @(posedge pclk) reset_sources <= reset_src_t'(src);
            settle;
            chk1("mcu_reset", 1'b1, mcu_reset);
            vec(16'hFFFE);
            @(posedge pclk) reset_sources <= '0;
            settle;
            apb(1'b0, `OFS_RESET_SOURCE, {24'h0, 1'b0, src[2], src[3], src[1:0], 3'h0});
        end
        @(posedge pclk);
        watchdog_enable <= 1'b0;
        reset_pin_enable <= 1'b0;
        reset_sources <= reset_src_t'(4'hC);
        settle;
        chk1("mcu_reset", 1'b0, mcu_reset);
        @(posedge pclk) reset_sources <= '0;
        apb(1'b1, `OFS_RESET_SOURCE, $random(seed));
        seen = 1'b0;
        repeat (3)
        begin
            #1;
            seen = seen | watchdog_clear;
            @(posedge pclk);
        end
        chk1("watchdog_clear", 1'b1, seen);
        apb(1'b0, `OFS_RESET_SOURCE, {24'h0, 1'b0, src[2], src[3], src[1:0], 3'h0});
        $display("test other sources done");
        @(posedge pclk) supply <= 8'd20;
        settle;
        chk1("mcu_reset", 1'b1, mcu_reset);
        @(posedge pclk) supply <= 8'd33;
        settle;
        apb(1'b0, `OFS_RESET_SOURCE, 32'h0000_0002);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge pclk) supply <= 8'(i == 0 ? 5 : i == 1 ? 15 : 33);
            settle;
            chk1("mcu_reset", i < 2, mcu_reset);
        end
        apb(1'b0, `OFS_RESET_SOURCE, 32'h0000_0082);
        $display("test mid-run power on done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
